// ==== src/ladder_pkg.sv ====
// Shared constants and types for the ladder bit logic engine
`default_nettype none
package ladder_pkg;
    localparam int ADDR_W      = 12;
    localparam int BIT_ADDR_W  = 12;
    localparam int OPC_W       = 4;
    localparam int STACK_DEPTH = 7;
    localparam int STACK_PTR_W = 3;
    localparam logic [ADDR_W-1:0] PROG_START = 12'h000;
    localparam logic [ADDR_W-1:0] PROG_LAST  = 12'hFFF;

    typedef enum logic [OPC_W-1:0] {
        OP_NOP       = 4'h0,
        OP_LOAD      = 4'h1,
        OP_LOAD_INV  = 4'h2,
        OP_AND       = 4'h3,
        OP_AND_INV   = 4'h4,
        OP_OR        = 4'h5,
        OP_OR_INV    = 4'h6,
        OP_OUT       = 4'h7,
        OP_OUT_INV   = 4'h8,
        OP_BLK_AND   = 4'h9,
        OP_BLK_OR    = 4'hA,
        OP_END       = 4'hF
    } opcode_e;

    typedef enum logic [2:0] {
        ST_SEARCH = 3'b001,
        ST_RUN    = 3'b010,
        ST_IDLE   = 3'b100
    } scan_state_e;
endpackage : ladder_pkg
`default_nettype wire

// ==== src/condition_stack.sv ====
// LIFO buffer of unused execution conditions
`timescale 1ns/1ps
`default_nettype none
module condition_stack (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic push,
    input  wire logic pop,
    input  wire logic push_bit,
    output logic      top_bit,
    output logic      empty,
    output logic      full
);
    localparam int D = ladder_pkg::STACK_DEPTH;
    logic [D-1:0]                        mem_r;
    logic [D-1:0]                        mem_nxt;
    logic [ladder_pkg::STACK_PTR_W:0]    cnt_r;
    logic [ladder_pkg::STACK_PTR_W:0]    cnt_nxt;

    assign empty   = (cnt_r == '0);
    assign full    = (cnt_r == (ladder_pkg::STACK_PTR_W + 1)'(D));
    assign top_bit = mem_r[0];

    // Shift register stack, newest at index 0
    always_comb begin
        mem_nxt = mem_r;
        cnt_nxt = cnt_r;
        if (clear) begin
            mem_nxt = '0;
            cnt_nxt = '0;
        end else if (push && !full) begin
            mem_nxt = {mem_r[D-2:0], push_bit};
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !empty) begin
            mem_nxt = {1'b0, mem_r[D-1:1]};
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r <= '0;
            cnt_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule : condition_stack
`default_nettype wire

// ==== src/ladder_bit_logic_engine.sv ====
// Bit logic execution core running a cyclic ladder scan
// How it works
// - Each scan runs instructions in order to first terminator, then restarts.
// - Instructions after the first terminator are never executed.
// - A program with no terminator executes nothing at all.
// - Terminator takes no operand and ignores the execution condition.
// - A mid-line load pushes the current condition, then restarts from operand.
// - Only loads after a line's first condition create unused conditions.
// - Block conjunction pops newest unused condition and ANDs it in.
// - Block disjunction pops newest unused condition and ORs it in.
// - Block combines have no operands; they use determined conditions only.
// - Buffer holds conditions for up to seven deferred blocks.
// - Combining right after each block allows unlimited blocks.
// - Deferred combines apply last-in-first-out, newest pair first.
// - Inverted OR ORs the condition with the operand's complement.
// - Load sets condition to operand; inverted load to its complement.
// - AND step ANDs operand; inverted AND uses its complement.
// - OR step ORs the operand bit into the condition.
// - Output drives operand bit to condition; inverted output to complement.
`timescale 1ns/1ps
`default_nettype none
module ladder_bit_logic_engine (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    output logic [ladder_pkg::ADDR_W-1:0]          prog_addr,
    input  wire logic [ladder_pkg::OPC_W-1:0]      prog_opcode,
    input  wire logic [ladder_pkg::BIT_ADDR_W-1:0] prog_operand,
    output logic [ladder_pkg::BIT_ADDR_W-1:0]      bit_rd_addr,
    input  wire logic                              bit_rd_data,
    output logic                                   bit_wr_en,
    output logic [ladder_pkg::BIT_ADDR_W-1:0]      bit_wr_addr,
    output logic                                   bit_wr_data,
    output logic                                   scan_done,
    output logic                                   running,
    output logic                                   stack_underflow,
    output logic                                   stack_overflow,
    output logic                                   exec_cond
);
    ladder_pkg::scan_state_e                state_r;
    ladder_pkg::scan_state_e                state_nxt;
    logic [ladder_pkg::ADDR_W-1:0]          pc_r;
    logic [ladder_pkg::ADDR_W-1:0]          pc_nxt;
    logic                                   cond_r;
    logic                                   cond_nxt;
    logic                                   line_open_r;
    logic                                   line_open_nxt;
    logic                                   wr_en_r;
    logic                                   wr_en_nxt;
    logic [ladder_pkg::BIT_ADDR_W-1:0]      wr_addr_r;
    logic [ladder_pkg::BIT_ADDR_W-1:0]      wr_addr_nxt;
    logic                                   wr_data_r;
    logic                                   wr_data_nxt;
    logic                                   done_r;
    logic                                   done_nxt;
    logic                                   under_r;
    logic                                   under_nxt;
    logic                                   over_r;
    logic                                   over_nxt;
    logic                                   running_r;
    logic                                   running_nxt;
    logic                                   stk_clear;
    logic                                   stk_push;
    logic                                   stk_pop;
    logic                                   stk_top;
    logic                                   stk_empty;
    logic                                   stk_full;
    ladder_pkg::opcode_e                    op;

    // Operand status, optionally inverted
    function automatic logic operand_val(input logic v, input logic inv);
        operand_val = inv ? ~v : v;
    endfunction : operand_val

    assign op              = ladder_pkg::opcode_e'(prog_opcode);
    assign prog_addr       = pc_r;
    assign bit_rd_addr     = prog_operand;
    assign bit_wr_en       = wr_en_r;
    assign bit_wr_addr     = wr_addr_r;
    assign bit_wr_data     = wr_data_r;
    assign scan_done       = done_r;
    assign running         = running_r;
    assign stack_underflow = under_r;
    assign stack_overflow  = over_r;
    assign exec_cond       = cond_r;

    condition_stack u_stack (
        .clk      (clk),
        .rst_n    (rst_n),
        .clear    (stk_clear),
        .push     (stk_push),
        .pop      (stk_pop),
        .push_bit (cond_r),
        .top_bit  (stk_top),
        .empty    (stk_empty),
        .full     (stk_full)
    );

    always_comb begin
        state_nxt     = state_r;
        pc_nxt        = pc_r;
        cond_nxt      = cond_r;
        line_open_nxt = line_open_r;
        wr_en_nxt     = 1'b0;
        wr_addr_nxt   = wr_addr_r;
        wr_data_nxt   = wr_data_r;
        done_nxt      = 1'b0;
        under_nxt     = under_r;
        over_nxt      = over_r;
        stk_clear     = 1'b0;
        stk_push      = 1'b0;
        stk_pop       = 1'b0;
        case (state_r)
            // Look for a terminator before running anything
            ladder_pkg::ST_SEARCH: begin
                if (op == ladder_pkg::OP_END) begin
                    state_nxt = ladder_pkg::ST_RUN;
                    pc_nxt    = ladder_pkg::PROG_START;
                    stk_clear = 1'b1;
                end else if (pc_r == ladder_pkg::PROG_LAST) begin
                    state_nxt = ladder_pkg::ST_IDLE;
                end else begin
                    pc_nxt = pc_r + 1'b1;
                end
            end
            // One instruction per cycle
            ladder_pkg::ST_RUN: begin
                pc_nxt = pc_r + 1'b1;
                case (op)
                    ladder_pkg::OP_LOAD, ladder_pkg::OP_LOAD_INV: begin
                        if (line_open_r) begin
                            stk_push = 1'b1;
                            if (stk_full) begin
                                over_nxt = 1'b1;
                            end
                        end
                        cond_nxt = operand_val(bit_rd_data,
                            op == ladder_pkg::OP_LOAD_INV);
                        line_open_nxt = 1'b1;
                    end
                    ladder_pkg::OP_AND, ladder_pkg::OP_AND_INV: begin
                        cond_nxt = cond_r & operand_val(bit_rd_data,
                            op == ladder_pkg::OP_AND_INV);
                    end
                    ladder_pkg::OP_OR: begin
                        cond_nxt = cond_r | bit_rd_data;
                    end
                    ladder_pkg::OP_OR_INV: begin
                        cond_nxt = cond_r | ~bit_rd_data;
                    end
                    ladder_pkg::OP_BLK_AND, ladder_pkg::OP_BLK_OR: begin
                        // Operand field unused here
                        if (stk_empty) begin
                            under_nxt = 1'b1;
                        end else begin
                            stk_pop = 1'b1;
                            cond_nxt = (op == ladder_pkg::OP_BLK_AND)
                                ? (stk_top & cond_r)
                                : (stk_top | cond_r);
                        end
                    end
                    ladder_pkg::OP_OUT, ladder_pkg::OP_OUT_INV: begin
                        wr_en_nxt     = 1'b1;
                        wr_addr_nxt   = prog_operand;
                        wr_data_nxt   = operand_val(cond_r,
                            op == ladder_pkg::OP_OUT_INV);
                        line_open_nxt = 1'b0;
                    end
                    ladder_pkg::OP_END: begin
                        pc_nxt        = ladder_pkg::PROG_START;
                        done_nxt      = 1'b1;
                        line_open_nxt = 1'b0;
                        stk_clear     = 1'b1;
                        state_nxt     = ladder_pkg::ST_SEARCH;
                    end
                    default: begin
                    end
                endcase
            end
            ladder_pkg::ST_IDLE: begin
                state_nxt = ladder_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = ladder_pkg::ST_SEARCH;
                pc_nxt    = ladder_pkg::PROG_START;
            end
        endcase
        running_nxt = (state_nxt == ladder_pkg::ST_RUN);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ladder_pkg::ST_SEARCH;
            pc_r        <= ladder_pkg::PROG_START;
            cond_r      <= 1'b0;
            line_open_r <= 1'b0;
            wr_en_r     <= 1'b0;
            wr_addr_r   <= '0;
            wr_data_r   <= 1'b0;
            done_r      <= 1'b0;
            under_r     <= 1'b0;
            over_r      <= 1'b0;
            running_r   <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            pc_r        <= pc_nxt;
            cond_r      <= cond_nxt;
            line_open_r <= line_open_nxt;
            wr_en_r     <= wr_en_nxt;
            wr_addr_r   <= wr_addr_nxt;
            wr_data_r   <= wr_data_nxt;
            done_r      <= done_nxt;
            under_r     <= under_nxt;
            over_r      <= over_nxt;
            running_r   <= running_nxt;
        end
    end
endmodule : ladder_bit_logic_engine
`default_nettype wire

// ==== tb/program_image.sv ====
// Program memory and bit image model
`timescale 1ns/1ps
`default_nettype none
module program_image (
    input  wire logic        clk,
    input  wire logic [11:0] prog_addr,
    output logic      [3:0]  prog_opcode,
    output logic      [11:0] prog_operand,
    input  wire logic [11:0] bit_rd_addr,
    output logic             bit_rd_data,
    input  wire logic        bit_wr_en,
    input  wire logic [11:0] bit_wr_addr,
    input  wire logic        bit_wr_data
);
    logic [3:0]  opc_mem [4096];
    logic [11:0] opd_mem [4096];
    logic        bits    [4096];
    assign prog_opcode  = opc_mem[prog_addr];
    assign prog_operand = opd_mem[prog_addr];
    assign bit_rd_data  = bits[bit_rd_addr];
    always @(posedge clk) if (bit_wr_en) bits[bit_wr_addr] <= bit_wr_data;
endmodule : program_image
`default_nettype wire

// ==== tb/ladder_monitor.sv ====
// Assertion checker for the ladder bit logic engine
`timescale 1ns/1ps
`default_nettype none
module ladder_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [11:0] prog_addr,
    input wire logic [3:0]  prog_opcode,
    input wire logic        bit_rd_data,
    input wire logic        bit_wr_en,
    input wire logic        bit_wr_data,
    input wire logic        scan_done,
    input wire logic        running,
    input wire logic        stack_underflow,
    input wire logic        stack_overflow,
    input wire logic        exec_cond
);
    logic [3:0] op;
    assign op = running ? prog_opcode : 4'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    load_value_a: assert property (op == ladder_pkg::OP_LOAD
        |=> exec_cond == $past(bit_rd_data)) else $error("load wrong");
    load_inv_a: assert property (op == ladder_pkg::OP_LOAD_INV
        |=> exec_cond == !$past(bit_rd_data)) else $error("inv load wrong");
    and_step_a: assert property (op == ladder_pkg::OP_AND
        |=> exec_cond == ($past(exec_cond) & $past(bit_rd_data)))
        else $error("and step wrong");
    and_inv_a: assert property (op == ladder_pkg::OP_AND_INV
        |=> exec_cond == ($past(exec_cond) & !$past(bit_rd_data)))
        else $error("inverted and step wrong");
    or_step_a: assert property (op == ladder_pkg::OP_OR
        |=> exec_cond == ($past(exec_cond) | $past(bit_rd_data)))
        else $error("or step wrong");
    or_inv_a: assert property (op == ladder_pkg::OP_OR_INV
        |=> exec_cond == ($past(exec_cond) | !$past(bit_rd_data)))
        else $error("inv or step wrong");
    out_write_a: assert property (op == ladder_pkg::OP_OUT
        |=> bit_wr_en && bit_wr_data == $past(exec_cond))
        else $error("output write wrong");
    out_inv_a: assert property (op == ladder_pkg::OP_OUT_INV
        |=> bit_wr_en && bit_wr_data == !$past(exec_cond))
        else $error("inv output write wrong");
    end_restart_a: assert property (op == ladder_pkg::OP_END
        |=> scan_done && !running && prog_addr == 12'h000)
        else $error("terminator restart wrong");
    step_next_a: assert property (running && op != ladder_pkg::OP_END
        |=> prog_addr == $past(prog_addr) + 12'h001)
        else $error("address step wrong");
    idle_quiet_a: assert property (!running |=> !bit_wr_en)
        else $error("write while not running");
    flag_sticky_a: assert property (stack_underflow |=> stack_underflow)
        else $error("underflow flag dropped");
    over_sticky_a: assert property (stack_overflow |=> stack_overflow)
        else $error("overflow flag dropped");
    under_cause_a: assert property ($rose(stack_underflow)
        |-> $past(op) == ladder_pkg::OP_BLK_AND
            || $past(op) == ladder_pkg::OP_BLK_OR)
        else $error("underflow without block combine");
    over_cause_a: assert property ($rose(stack_overflow)
        |-> $past(op) == ladder_pkg::OP_LOAD
            || $past(op) == ladder_pkg::OP_LOAD_INV)
        else $error("overflow without load");
    cover property (scan_done);
    cover property ($rose(stack_overflow));
    cover property ($rose(stack_underflow));
    cover property (op == ladder_pkg::OP_BLK_OR);
endmodule : ladder_monitor
bind ladder_bit_logic_engine ladder_monitor u_ladder_monitor (
    .clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_opcode(prog_opcode), .bit_rd_data(bit_rd_data),
    .bit_wr_en(bit_wr_en), .bit_wr_data(bit_wr_data),
    .scan_done(scan_done), .running(running),
    .stack_underflow(stack_underflow), .stack_overflow(stack_overflow),
    .exec_cond(exec_cond));
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench for the ladder bit logic engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk;
    logic        rst_n;
    logic [11:0] prog_addr, prog_operand, bit_rd_addr, bit_wr_addr;
    logic [3:0]  prog_opcode;
    logic        bit_rd_data, bit_wr_en, bit_wr_data, scan_done, running;
    logic        stack_underflow, stack_overflow, exec_cond;
    int          failures = 0;
    int          samples_checked = 0;
    ladder_bit_logic_engine u_ladder_bit_logic_engine (.clk(clk),
        .rst_n(rst_n), .prog_addr(prog_addr), .prog_opcode(prog_opcode),
        .prog_operand(prog_operand), .bit_rd_addr(bit_rd_addr),
        .bit_rd_data(bit_rd_data), .bit_wr_en(bit_wr_en),
        .bit_wr_addr(bit_wr_addr), .bit_wr_data(bit_wr_data),
        .scan_done(scan_done), .running(running),
        .stack_underflow(stack_underflow),
        .stack_overflow(stack_overflow), .exec_cond(exec_cond));
    program_image u_program_image (.clk(clk), .prog_addr(prog_addr),
        .prog_opcode(prog_opcode), .prog_operand(prog_operand),
        .bit_rd_addr(bit_rd_addr), .bit_rd_data(bit_rd_data),
        .bit_wr_en(bit_wr_en), .bit_wr_addr(bit_wr_addr),
        .bit_wr_data(bit_wr_data));
    task automatic stop_test;
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (scan_done !== 1'b1 && n < 5000);
        chk(scan_done, 1'b1);
    endtask : wait_done
    // Words are opcode nibble and operand; e holds value and bit address
    task automatic run(input logic [15:0] p[$], input logic [12:0] e[$],
                       input logic ends);
        @(negedge clk);
        rst_n = 1'b0;
        for (int i = 0; i < 4096; i++) begin
            u_program_image.opc_mem[i] = 4'h0;
            u_program_image.opd_mem[i] = 12'h000;
            u_program_image.bits[i] = ~i[0];
        end
        foreach (p[i]) u_program_image.opc_mem[i] = p[i][15:12];
        foreach (p[i]) u_program_image.opd_mem[i] = p[i][11:0];
        foreach (e[i]) u_program_image.bits[e[i][11:0]] = ~e[i][12];
        @(negedge clk);
        rst_n = 1'b1;
        if (ends) wait_done();
        else repeat (4400) @(negedge clk);
        foreach (e[i]) chk(u_program_image.bits[e[i][11:0]], e[i][12]);
    endtask : run
    task automatic test_steps;
        run('{16'h1000, 16'h4001, 16'h5003, 16'h7100, 16'h8101, 16'h2000,
              16'h6002, 16'h7102, 16'h1001, 16'h6003, 16'h3002, 16'h7103,
              16'hFFFF}, '{13'h1100, 13'h0101, 13'h0102, 13'h1103},
            1'b1);
    endtask : test_steps
    task automatic test_blocks;
        run('{16'h1000, 16'h5001, 16'h1001, 16'h6002, 16'h9000, 16'h7104,
              16'h1000, 16'h4003, 16'h1001, 16'h3002, 16'hA000, 16'h7105,
              16'hF000}, '{13'h0104, 13'h1105}, 1'b1);
        chk(stack_underflow, 1'b0);
        run('{16'h1001, 16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000,
              16'h1000, 16'h1000, 16'h9000, 16'hA000, 16'hA000, 16'hA000,
              16'hA000, 16'hA000, 16'h9000, 16'h7106, 16'hF000},
            '{13'h0106}, 1'b1);
        chk(stack_overflow, 1'b0);
    endtask : test_blocks
    task automatic test_series;
        logic [15:0] p[$];
        p = '{16'h1001};
        repeat (11) begin
            p.push_back(16'h1000);
            p.push_back(16'hA000);
        end
        p.push_back(16'h7107);
        p.push_back(16'hF000);
        run(p, '{13'h1107}, 1'b1);
        chk(stack_overflow, 1'b0);
    endtask : test_series
    task automatic test_errors;
        run('{16'h9000, 16'hF000}, '{}, 1'b1);
        chk(stack_underflow, 1'b1);
        run('{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000,
              16'h1000, 16'h1000, 16'h1000, 16'hF000}, '{}, 1'b1);
        chk(stack_overflow, 1'b1);
        run('{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000,
              16'h1000, 16'hF000}, '{}, 1'b1);
        wait_done();
        chk(stack_overflow, 1'b0);
    endtask : test_errors
    task automatic test_terminator;
        run('{16'h2000, 16'h7108, 16'hF000, 16'h8109}, '{13'h0108},
            1'b1);
        chk(u_program_image.bits[12'h109], 1'b0);
        wait_done();
        chk(u_program_image.bits[12'h109], 1'b0);
        run('{16'h1000, 16'h810A}, '{}, 1'b0);
        chk(u_program_image.bits[12'h10A], 1'b1);
        chk(running, 1'b0);
    endtask : test_terminator
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        test_steps();
        test_blocks();
        test_series();
        test_errors();
        test_terminator();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
